// ### sar_defines.vh
`ifndef SAR_DEFINES_VH
`define SAR_DEFINES_VH
// ****************
// frame layout
// ****************
`define SAR_FRAME_BITS 16
`define SAR_LEAD_ZEROS 4
`define SAR_RESULT_BITS 12
`define SAR_CNT_W 5
// ****************
// timing
// ****************
`define SAR_CLK_PERIOD_NS 10
`define SAR_QUIET_NS 50
`define SAR_QUIET_CYC ((`SAR_QUIET_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)
`endif

// ### sar_edge_sync.v
`default_nettype none
// ****************
// two-flop synchroniser with edge detect
// ****************
module sar_edge_sync (
	input wire mclk_in,
	input wire rstn_in,
	input wire async_in,
	output reg level_out,
	output wire rise_out,
	output wire fall_out
);
	reg meta;
	reg sync;
	always @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			meta <= 1'b1;
			sync <= 1'b1;
			level_out <= 1'b1;
		end else begin
			meta <= async_in;
			sync <= meta;
			level_out <= sync;
		end
	end
	assign rise_out = sync & ~level_out;
	assign fall_out = ~sync & level_out;
endmodule
`default_nettype wire

// ### sar_readout.v
// Summary of operation
// R01: falling chip select starts a conversion; its low time frames the transfer
// R02: serial clock is the only conversion clock; sixteen periods per conversion; here all logic runs on mclk_in, which samples sclk_in edges
// R03: each output bit changes on a serial clock falling edge; here the first leading zero is driven when select falls
// R04: sixteen-bit word: four zeros then twelve result bits, msb first
// R05: data output released while select high, driven after select falls
// R06: data line released after the final falling serial clock edge
// R07: host leaves at least 50 ns quiet before the next select fall
// R08: host serial clock 10 kHz to 12 MHz, duty 40/60 to 60/40
// R09: host holds select low sixteen clocks, samples data on rising edges; sar_host takes each bit just before the clock fall
`include "sar_defines.vh"
`default_nettype none
module sar_readout #(
	parameter RESULT_W = `SAR_RESULT_BITS
) (
	input wire mclk_in,
	input wire rstn_in,
	input wire cs_n_in,
	input wire sclk_in,
	input wire [RESULT_W-1:0] sample_in,
	output reg serial_result_out,
	output reg serial_result_oe_out,
	output reg busy_out,
	output reg [RESULT_W-1:0] result_out,
	output reg result_valid_out,
	output reg quiet_ok_out
);
	// ****************
	// states
	// ****************
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_SHIFT = 3'b010;
	localparam [2:0] ST_DONE = 3'b100;
	localparam integer LAST_BIT_I = `SAR_FRAME_BITS - 1;
	localparam integer QUIET_CYC_I = `SAR_QUIET_CYC;
	localparam [`SAR_CNT_W-1:0] LAST_BIT = LAST_BIT_I[`SAR_CNT_W-1:0];
	localparam [7:0] QUIET_CYC = QUIET_CYC_I[7:0];

	wire cs_n;
	wire cs_fall;
	wire cs_rise;
	wire sclk_fall;
	reg [2:0] state;
	reg [`SAR_CNT_W-1:0] bit_cnt;
	reg [`SAR_FRAME_BITS-1:0] shreg;
	reg [RESULT_W-1:0] held;
	reg [7:0] quiet_cnt;
	reg [2:0] next_state;

	// ****************
	// synchronised pins
	// ****************
	sar_edge_sync u_cs (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.async_in(cs_n_in),
		.level_out(cs_n),
		.rise_out(cs_rise),
		.fall_out(cs_fall)
	);
	sar_edge_sync u_sclk (
		.mclk_in(mclk_in),
		.rstn_in(rstn_in),
		.async_in(sclk_in),
		.level_out(),
		.rise_out(),
		.fall_out(sclk_fall)
	);

	// ****************
	// next state
	// ****************
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (cs_fall) next_state = ST_SHIFT; // [R01]
			end
			ST_SHIFT: begin
				if (cs_rise) next_state = ST_IDLE; // [R01]
				else if (sclk_fall && bit_cnt == LAST_BIT) next_state = ST_DONE; // [R06]
			end
			ST_DONE: begin
				if (cs_rise) next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// ****************
	// shifter and output
	// ****************
	always @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state <= ST_IDLE;
			bit_cnt <= {`SAR_CNT_W{1'b0}};
			shreg <= 16'h0000;
			held <= {RESULT_W{1'b0}};
			serial_result_out <= 1'b0;
			serial_result_oe_out <= 1'b0;
			busy_out <= 1'b0;
			result_out <= {RESULT_W{1'b0}};
			result_valid_out <= 1'b0;
		end else begin
			state <= next_state;
			result_valid_out <= 1'b0;
			case (state)
				ST_IDLE: begin
					serial_result_oe_out <= 1'b0; // [R05]
					if (cs_fall) begin
						shreg <= {{`SAR_LEAD_ZEROS{1'b0}}, sample_in}; // [R04]
						held <= sample_in;
						bit_cnt <= {`SAR_CNT_W{1'b0}};
						serial_result_out <= 1'b0; // [R04]
						serial_result_oe_out <= 1'b1; // [R05]
						busy_out <= 1'b1; // [R01]
					end
				end
				ST_SHIFT: begin
					if (cs_rise) begin
						serial_result_oe_out <= 1'b0; // [R05]
						busy_out <= 1'b0;
					end else if (sclk_fall) begin // [R02]
						if (bit_cnt == LAST_BIT) begin
							serial_result_oe_out <= 1'b0; // [R06]
							busy_out <= 1'b0; // [R02]
							result_out <= held;
							result_valid_out <= 1'b1;
						end else begin
							bit_cnt <= bit_cnt + 1'b1;
							serial_result_out <= shreg[`SAR_FRAME_BITS-2]; // [R03]
							shreg <= {shreg[`SAR_FRAME_BITS-2:0], 1'b0}; // [R04]
						end
					end
				end
				ST_DONE: begin
					serial_result_oe_out <= 1'b0; // [R06]
				end
				default: begin
					serial_result_oe_out <= 1'b0;
					busy_out <= 1'b0;
				end
			endcase
		end
	end

	// ****************
	// quiet interval monitor
	// ****************
	always @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			quiet_cnt <= QUIET_CYC;
			quiet_ok_out <= 1'b1;
		end else if (serial_result_oe_out || !cs_n) begin
			quiet_cnt <= 8'h00;
			quiet_ok_out <= 1'b0;
		end else if (quiet_cnt < QUIET_CYC) begin
			quiet_cnt <= quiet_cnt + 8'h01;
			quiet_ok_out <= (quiet_cnt + 8'h01) >= QUIET_CYC; // [R07]
		end
	end
endmodule
`default_nettype wire

// ### sar_checker.sv
`default_nettype none
module sar_checker (
	input wire mclk_in,
	input wire rstn_in,
	input wire cs_n_in,
	input wire sclk_in,
	input wire serial_result_out,
	input wire serial_result_oe_out,
	input wire busy_out,
	input wire result_valid_out
);
	timeunit 1ns;
	timeprecision 1ns;
	wire oe = serial_result_oe_out;
	wire d = serial_result_out;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);
	a_frame_start: assert property ($fell(cs_n_in) && !busy_out |-> ##[3:5] oe && !d && busy_out)
		else $error("frame did not start");
	a_idle_off: assert property (!busy_out |-> !oe)
		else $error("pin driven when idle");
	a_bit_fall: assert property (oe && $past(oe) && $changed(d) |-> !$past(sclk_in, 3))
		else $error("bit moved without clock fall");
	a_end_release: assert property ($fell(oe) |-> !$past(sclk_in, 3) || $past(cs_n_in, 3))
		else $error("early release");
	a_pulse_end: assert property (result_valid_out |-> $past(busy_out) && !oe ##1 !result_valid_out)
		else $error("bad result pulse");
	a_lead_zero: assert property ($rose(oe) |-> !d [*8])
		else $error("lead bit not zero");
endmodule
`default_nettype wire

// ### sar_host.sv
`default_nettype none
module sar_host (
	input wire logic mclk_in,
	input wire logic data_in,
	output logic cs_n_out,
	output logic sclk_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b1;
	end
	// one frame; each bit taken just before the next clock fall
	task automatic frame(input int half, input int nclk, output logic [15:0] word);
		word = 16'h0000;
		@(negedge mclk_in) cs_n_out = 1'b0;
		repeat (nclk) begin
			repeat (half) @(negedge mclk_in);
			word = {word[14:0], data_in};
			sclk_out = 1'b0;
			repeat (half) @(negedge mclk_in);
			sclk_out = 1'b1;
		end
		repeat (half) @(negedge mclk_in);
		cs_n_out = 1'b1;
		repeat (10) @(negedge mclk_in);
	endtask
endmodule
`default_nettype wire

// ### tb_serial_adc_readout_frame.sv
`default_nettype none
module tb_serial_adc_readout_frame;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [11:0] sample_in = 12'h000;
	logic [15:0] word;
	logic [15:0] model_q[$];
	wire cs_n, sclk, sdo, oe, vld, qok;
	wire [11:0] res;
	int seed = 15237;
	int n_errors = 0;
	int checked = 0;
	int pulses = 0;
	initial forever #5 mclk_in = ~mclk_in;
	sar_readout sar_readout_inst (.mclk_in(mclk_in), .rstn_in(rstn_in), .cs_n_in(cs_n), .sclk_in(sclk),
		.sample_in(sample_in), .serial_result_out(sdo), .serial_result_oe_out(oe), .busy_out(),
		.result_out(res), .result_valid_out(vld), .quiet_ok_out(qok));
	sar_host sar_host_inst (.mclk_in(mclk_in), .data_in(oe ? sdo : 1'bz), .cs_n_out(cs_n), .sclk_out(sclk));
	always @(posedge mclk_in) if (vld === 1'b1) pulses++;
	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		int p;
		bit abort;
		logic [15:0] exp_word;
		exp_word = 16'h0000;
		repeat (12) @(negedge mclk_in);
		rstn_in = 1'b1;
		cmp("idle oe", 16'h0000, {15'h0, oe});
		for (int i = 0; i < 7; i++) begin
			abort = i == 3;
			sample_in = i == 0 ? 12'hFFF : 12'($random(seed));
			p = pulses;
			if (!abort) model_q.push_back({4'h0, sample_in});
			sar_host_inst.frame(5 + i, abort ? 8 : 16, word);
			if (!abort) begin
				exp_word = model_q.pop_front();
				cmp("word", exp_word, word);
			end
			cmp("result", exp_word, {4'h0, res});
			cmp("pulses", 16'(p + (abort ? 0 : 1)), 16'(pulses));
			cmp("release", 16'h0001, {14'h0, oe, qok});
			$display("frame %0d done", i);
		end
		report_and_stop();
	end
endmodule
bind sar_readout sar_checker sar_checker_inst (.mclk_in(mclk_in), .rstn_in(rstn_in), .cs_n_in(cs_n_in),
	.sclk_in(sclk_in), .serial_result_out(serial_result_out), .serial_result_oe_out(serial_result_oe_out),
	.busy_out(busy_out), .result_valid_out(result_valid_out));
`default_nettype wire
